// ---- rtl/och_pkg.sv ----
// Purpose: shared constants, types and helpers of the overcurrent hiccup sequencer
// Assumes: 100 MHz system clock
// Notes: time figures are kept in ns, cycle counts are derived from them
package och_pkg;

  // clock period
  localparam int unsigned CLK_PERIOD_NS = 10;

  // delay from enable to trip-level sampling, minimum time so round up
  localparam int unsigned POR_DELAY_NS = 6_800_000;
  localparam int unsigned POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // soft-start ramp, one staircase of equal steps
  localparam int unsigned SS_RAMP_NS = 6_800_000;
  localparam int unsigned SS_STEPS = 64;
  localparam int unsigned SS_STEP_CYC = SS_RAMP_NS / (SS_STEPS * CLK_PERIOD_NS);

  // longest sample-and-hold phase, spread over the set-code range
  localparam int unsigned SAMPLE_MAX_NS = 3_400_000;
  localparam int unsigned SET_CODE_STEPS = 128;
  localparam int unsigned SAMPLE_STEP_CYC = SAMPLE_MAX_NS / (SET_CODE_STEPS * CLK_PERIOD_NS);

  // blanking after the low-side rising edge, minimum so round up
  localparam int unsigned BLANK_NS = 200;
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // minimum low-side width for a stretched or inserted pulse
  localparam int unsigned MIN_LOW_NS = 425;
  localparam int unsigned MIN_LOW_CYC = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // field widths
  localparam int unsigned TMR_W = 20;
  localparam int unsigned SS_W = 6;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned CNT_W = 6;

  // set-code ceiling, the upper set-voltage limit
  localparam logic [CODE_W-1:0] SET_CODE_MAX = 7'h7F;
  // last step of the staircase
  localparam logic [SS_W-1:0] SS_LAST = 6'h3F;
  // cycle counts at counter width
  localparam logic [CNT_W-1:0] BLANK_CNT = CNT_W'(BLANK_CYC);
  localparam logic [CNT_W-1:0] MIN_LOW_CNT = CNT_W'(MIN_LOW_CYC);

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    OCH_OFF = 6'h01,
    OCH_DELAY = 6'h02,
    OCH_SAMPLE = 6'h04,
    OCH_SOFT = 6'h08,
    OCH_RUN = 6'h10,
    OCH_DUMMY = 6'h20
  } och_state_e;

  // whole state of the sequencer
  typedef struct packed {
    och_state_e st;
    logic [TMR_W-1:0] tmr;
    logic [SS_W-1:0] ss_idx;
    logic dummy_n;
    logic [CODE_W-1:0] code;
    logic guard_en;
    logic low_gate;
    logic high_gate;
    logic [CNT_W-1:0] blank_cnt;
    logic [CNT_W-1:0] width_cnt;
    logic narrow_n;
    logic [CNT_W-1:0] force_cnt;
  } och_state_s;

  // whole state of the input synchroniser
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stable;
  } och_sync_s;

  localparam och_state_s OCH_RST = '{st: OCH_OFF, default: '0};
  localparam och_sync_s OCH_SYNC_RST = '{default: '0};

  // true on the last cycle of a period of lim cycles
  function automatic logic och_timer_hit(input logic [TMR_W-1:0] t, input int unsigned lim);
    return t == TMR_W'(lim - 1);
  endfunction : och_timer_hit

endpackage : och_pkg

// ---- rtl/och_sync.sv ----
// Purpose: two-flop synchroniser for the asynchronous inputs
// Assumes: inputs are slow levels from pins or analog comparators
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module och_sync
  import och_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);

  // registered state and its next value
  och_sync_s q;
  och_sync_s d;

  // next state: shift one stage
  always_comb
  begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      q <= OCH_SYNC_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // second stage only
  assign sync_out = q.stable;

endmodule : och_sync

// ---- rtl/och_sequencer.sv ----
// Purpose: trip-level sample, soft-start, hiccup retry and low-side guard logic
// Assumes: pwm requests and cycle start come from logic on sys_clk
// Notes: shutdown pin, set comparator and trip comparator are asynchronous
//
// Summary of operation
// - enable release repeats init with fresh sample
// - no new sample during overcurrent retries
// - trip: output off, two dummies, one attempt
// - hiccup repeats endlessly, never latches off
// - after delay sample, low driver off, sense on
// - set level held in counter feeding DAC
// - monitoring starts after blanking from low rise
// - window ends at low fall, trip anywhere
// - third narrow low pulse stretched to minimum
// - guard disabled also disables pulse stretching
// - threshold is twice the sampled set voltage
// - set pin still above the dac at ceiling code disables the guard
// - trip during real attempt restarts dummies
// - guard enabled by the sample is active in soft-start too
// - retry period two dummies plus partial ramp
// - short removed, next attempt ramps normally
// - soft-start reference is sixty-four equal steps
// - shutdown stops oscillator, gates low, re-arms
// - sample phase time grows with trip setting
`timescale 1ns/1ps
module och_sequencer
  import och_pkg::*;
#(
  parameter int unsigned POR_DELAY_CYCLES = POR_DELAY_CYC,
  parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic shutdown_compensation_pin,
  input wire logic set_pin_above_dac,
  input wire logic overcurrent_sense,
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  input wire logic pwm_cycle_start,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic osc_run,
  output logic error_amp_en,
  output logic [SS_W-1:0] soft_ref,
  output logic trip_sense_current_en,
  output logic [CODE_W-1:0] set_dac_code,
  output logic [CODE_W:0] trip_dac_code,
  output logic overcurrent_guard_en,
  output logic hiccup_active
);

  // registered state and its next value
  och_state_s q;
  och_state_s d;
  // synchronised pin and comparator levels
  logic [2:0] sync_lv;
  // shutdown released (pin above disable level)
  logic sd_rel;
  // set pin still above the set dac
  logic above;
  // low-side drop above the trip threshold
  logic oc_hit;
  // sequencer drives the gates this cycle
  logic active;
  // overcurrent seen inside the window
  logic trip;
  // next cycle keeps the gates enabled
  logic run;
  // low pulse reached minimum width this cycle
  logic wide;

  // all three asynchronous inputs pass two flops
  och_sync u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .async_in ({overcurrent_sense, set_pin_above_dac, shutdown_compensation_pin}),
    .sync_out (sync_lv)
  );

  assign sd_rel = sync_lv[0];
  assign above = sync_lv[1];
  assign oc_hit = sync_lv[2];

  // next-state logic
  always_comb
  begin
    d = q;
    active = (q.st == OCH_SOFT) || (q.st == OCH_RUN);
    // window closes with low gate fall
    trip = active && q.guard_en && q.low_gate && (q.blank_cnt == BLANK_CNT) && oc_hit;
    d.tmr = TMR_W'(q.tmr + TMR_W'(1));
    case (q.st)
      // disabled, waiting for release
      OCH_OFF:
      begin
        d.tmr = '0;
        if (sd_rel)
        begin
          d.st = OCH_DELAY;
          d.guard_en = 1'b0;
        end
      end
      // fixed delay, sense current already on
      OCH_DELAY:
      begin
        if (och_timer_hit(q.tmr, POR_DELAY_CYCLES))
        begin
          d.st = OCH_SAMPLE;
          d.tmr = '0;
          d.code = '0;
        end
      end
      // counter ramps the set dac up to the pin voltage
      OCH_SAMPLE:
      begin
        if (och_timer_hit(q.tmr, SAMPLE_STEP_CYC))
        begin
          d.tmr = '0;
          if (!above)
          begin
            d.st = OCH_SOFT;
            d.guard_en = 1'b1;
            d.ss_idx = '0;
          end
          else if (q.code == SET_CODE_MAX)
          begin
            d.st = OCH_SOFT;
            d.guard_en = 1'b0;
            d.ss_idx = '0;
          end
          else
          begin
            d.code = CODE_W'(q.code + CODE_W'(1));
          end
        end
      end
      // real soft-start ramp
      OCH_SOFT:
      begin
        if (och_timer_hit(q.tmr, SS_STEP_CYCLES))
        begin
          d.tmr = '0;
          if (q.ss_idx == SS_LAST)
          begin
            d.st = OCH_RUN;
          end
          else
          begin
            d.ss_idx = SS_W'(q.ss_idx + SS_W'(1));
          end
        end
      end
      // regulating, reference at final step
      OCH_RUN:
      begin
        d.tmr = '0;
      end
      // dummy time-out, one full ramp long
      OCH_DUMMY:
      begin
        if (och_timer_hit(q.tmr, SS_STEP_CYCLES))
        begin
          d.tmr = '0;
          if (q.ss_idx == SS_LAST)
          begin
            d.ss_idx = '0;
            // second dummy leads to one attempt
            if (q.dummy_n)
            begin
              d.st = OCH_SOFT;
              d.dummy_n = 1'b0;
            end
            else
            begin
              d.dummy_n = 1'b1;
            end
          end
          else
          begin
            d.ss_idx = SS_W'(q.ss_idx + SS_W'(1));
          end
        end
      end
      // illegal code, fall back to off
      default:
      begin
        d.st = OCH_OFF;
        d.tmr = '0;
      end
    endcase
    // trip shuts off and enters hiccup
    if (trip)
    begin
      d.st = OCH_DUMMY;
      d.tmr = '0;
      d.ss_idx = '0;
      d.dummy_n = 1'b0;
    end
    if (!sd_rel)
    begin
      d.st = OCH_OFF;
      d.tmr = '0;
      d.ss_idx = '0;
      d.dummy_n = 1'b0;
    end
    // gates only in soft-start or regulation
    run = (d.st == OCH_SOFT) || (d.st == OCH_RUN);
    // forced pulse counts down
    if (q.force_cnt != '0)
    begin
      d.force_cnt = CNT_W'(q.force_cnt - CNT_W'(1));
    end
    d.low_gate = run && (pwm_low_req || (q.force_cnt != '0));
    // high only with low off both cycles
    d.high_gate = run && pwm_high_req && !d.low_gate && !q.low_gate;
    // width and blanking counters
    wide = (q.width_cnt == MIN_LOW_CNT);
    if (d.low_gate && !q.low_gate)
    begin
      d.blank_cnt = '0;
      d.width_cnt = '0;
    end
    else if (q.low_gate)
    begin
      if (q.blank_cnt != BLANK_CNT)
      begin
        d.blank_cnt = CNT_W'(q.blank_cnt + CNT_W'(1));
      end
      if (!wide)
      begin
        d.width_cnt = CNT_W'(q.width_cnt + CNT_W'(1));
      end
    end
    // third narrow cycle gets forced pulse
    if (!run || !q.guard_en)
    begin
      d.narrow_n = 1'b0;
      d.force_cnt = '0;
    end
    else if (pwm_cycle_start)
    begin
      d.width_cnt = '0;
      if (wide)
      begin
        d.narrow_n = 1'b0;
      end
      else if (q.narrow_n)
      begin
        d.narrow_n = 1'b0;
        d.force_cnt = MIN_LOW_CNT;
      end
      else
      begin
        d.narrow_n = 1'b1;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      q <= OCH_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from state
  assign high_side_gate = q.high_gate;
  assign low_side_gate = q.low_gate;
  assign osc_run = (q.st != OCH_OFF);
  assign error_amp_en = (q.st == OCH_SOFT) || (q.st == OCH_RUN);
  assign soft_ref = error_amp_en ? q.ss_idx : '0;
  assign trip_sense_current_en = (q.st == OCH_DELAY) || (q.st == OCH_SAMPLE);
  assign set_dac_code = q.code;
  // threshold is twice the set code
  assign trip_dac_code = {q.code, 1'b0};
  assign overcurrent_guard_en = q.guard_en;
  assign hiccup_active = (q.st == OCH_DUMMY);

  // checks on the sequencer
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_gate_no_overlap: assert property (!(high_side_gate && low_side_gate))
    else $error("both gates on");
  a_off_gates_low: assert property ((q.st == OCH_OFF) |-> (!high_side_gate && !low_side_gate && !osc_run))
    else $error("gate or oscillator active while off");
  a_dummy_gates_low: assert property ((q.st == OCH_DUMMY) |-> (!high_side_gate && !low_side_gate))
    else $error("gate active during dummy");
  a_trip_to_hiccup: assert property ((trip && sd_rel) |=> (hiccup_active && !low_side_gate && q.dummy_n == 1'b0))
    else $error("trip did not enter hiccup");
  a_code_held: assert property ((q.st inside {OCH_SOFT, OCH_RUN, OCH_DUMMY}) |=> $stable(q.code))
    else $error("set code changed outside sampling");
  a_blank_no_trip: assert property ($rose(low_side_gate) |-> (!trip) [*8])
    else $error("trip inside blanking");
  a_forced_width: assert property (($rose(low_side_gate) && q.force_cnt != '0) |-> (low_side_gate || !sd_rel) [*8])
    else $error("forced low pulse too short");
  a_no_stretch_off: assert property ((!q.guard_en) |=> (q.force_cnt == '0))
    else $error("stretching without guard");
  a_release_resample: assert property ((q.st == OCH_OFF && sd_rel) |=> (q.st == OCH_DELAY ##1 trip_sense_current_en))
    else $error("release did not restart init");
  a_ramp_step: assert property ((q.st == OCH_SOFT && $past(q.st) == OCH_SOFT && $changed(q.ss_idx))
    |-> (q.ss_idx == SS_W'($past(q.ss_idx) + SS_W'(1))))
    else $error("soft-start step not by one");
  a_ceiling_off: assert property ((q.st == OCH_SAMPLE && q.code == SET_CODE_MAX && above && sd_rel
    && och_timer_hit(q.tmr, SAMPLE_STEP_CYC)) |=> (!overcurrent_guard_en && q.st == OCH_SOFT))
    else $error("ceiling code left guard enabled");

endmodule : och_sequencer

// ---- sim/och_stage_model.sv ----
// Purpose: power stage and set resistor model facing the sequencer
// Assumes: gates and codes come from the sequencer on sys_clk
// Notes: the drop sense only means something while the low-side switch conducts
`timescale 1ns/1ps
module och_stage_model
  import och_pkg::*;
(
  input wire logic sys_clk,
  input wire logic short_on,
  input wire logic [7:0] set_level,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic [CODE_W-1:0] set_dac_code,
  output logic set_pin_above_dac,
  output logic overcurrent_sense,
  output int overlap_cnt
);
  logic tgl_q = 1'h0; // phase node ringing while low switch is off
  int ovl_q = 0; // shoot-through cycles seen
  assign overlap_cnt = ovl_q;
  // set node stays above the dac until the code reaches the level
  assign set_pin_above_dac = set_level > {1'h0, set_dac_code};
  // shorted output drops more than twice the set level; noise when low is off
  assign overcurrent_sense = short_on & (low_side_gate | tgl_q);
  // noise source and shoot-through watch
  always @(posedge sys_clk)
  begin
    tgl_q <= ~tgl_q;
    // both switches on counts a fault
    if (high_side_gate && low_side_gate)
      ovl_q <= ovl_q + 1;
  end
endmodule : och_stage_model

// ---- sim/och_sequencer_tb.sv ----
// Purpose: self-checking bench of the overcurrent hiccup sequencer
// Assumes: shortened delay and ramp step, pwm made by the bench
// Notes: the no-resistor case is left out, its sampling runs too long
`timescale 1ns/1ps
module och_sequencer_tb
  import och_pkg::*;
;
  localparam int POR = 200; // shortened delay
  localparam int SS = 20; // shortened ramp step
  localparam int DUM = 64 * SS; // one dummy time-out
  localparam int PER = 60; // switching period
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic sd_pin = 1'h0; // shutdown pin, low holds off
  logic hi_req = 1'h0;
  logic lo_req = 1'h0;
  logic cyc_start = 1'h0;
  logic short_on = 1'h0; // shorted output
  logic pwm_en = 1'h0;
  logic low_prev = 1'h0;
  logic clr_max = 1'h0; // clears the widest-pulse record
  int hi_cnt = 0; // high-side gate on cycles
  logic [7:0] set_level = 8'h02; // set resistor level in code steps
  logic above, sense, hsg, lsg, osc_run, ea_en, tsc_en, guard_en, hiccup;
  logic [SS_W-1:0] soft_ref;
  logic [CODE_W-1:0] set_code;
  logic [CODE_W:0] trip_code;
  int overlap, n_errors = 0, num_checks = 0, ph = 0, low_w = 0, low_run = 0, low_max = 0;

  och_sequencer #(.POR_DELAY_CYCLES(POR), .SS_STEP_CYCLES(SS)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .shutdown_compensation_pin(sd_pin),
    .set_pin_above_dac(above), .overcurrent_sense(sense), .pwm_high_req(hi_req),
    .pwm_low_req(lo_req), .pwm_cycle_start(cyc_start), .high_side_gate(hsg),
    .low_side_gate(lsg), .osc_run(osc_run), .error_amp_en(ea_en), .soft_ref(soft_ref),
    .trip_sense_current_en(tsc_en), .set_dac_code(set_code), .trip_dac_code(trip_code),
    .overcurrent_guard_en(guard_en), .hiccup_active(hiccup));

  och_stage_model stage_u (
    .sys_clk(sys_clk), .short_on(short_on), .set_level(set_level), .high_side_gate(hsg),
    .low_side_gate(lsg), .set_dac_code(set_code), .set_pin_above_dac(above),
    .overcurrent_sense(sense), .overlap_cnt(overlap));

  // clock, 10 ns period
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // pwm source, high first, low at the end of each period
  always @(negedge sys_clk)
  begin
    ph <= (ph == PER - 1) ? 0 : ph + 1;
    cyc_start <= pwm_en && ph == 0;
    hi_req <= pwm_en && ph > 0 && ph < PER - low_w - 2;
    lo_req <= pwm_en && ph >= PER - low_w;
  end

  // low pulse widths seen at the gate
  always @(posedge sys_clk)
  begin
    low_prev <= lsg;
    if (lsg)
      low_run <= low_prev ? low_run + 1 : 1;
    if (clr_max)
      low_max <= 0;
    else if (lsg && low_prev && low_run + 1 > low_max)
      low_max <= low_run + 1;
    if (hsg)
      hi_cnt <= hi_cnt + 1;
  end

  // one edge of clearing for the widest-pulse record
  task automatic clear_max();
    clr_max = 1'h1;
    @(negedge sys_clk);
    clr_max = 1'h0;
  endtask : clear_max

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // watched outputs by index
  function automatic logic [7:0] probe(input int k);
    case (k)
      0: return {7'h00, hiccup};
      1: return {7'h00, ea_en};
      default: return {2'h0, soft_ref};
    endcase
  endfunction : probe

  // bounded wait, n counts the cycles spent
  task automatic wait_for(input int k, input logic [7:0] v, input int lim, output int n);
    n = 0;
    while (probe(k) !== v)
    begin
      @(negedge sys_clk);
      n++;
      if (n > lim)
      begin
        n_errors++;
        $display("ERROR wait %0d expected %0h seen %0h", k, v, probe(k));
        results();
      end
    end
  endtask : wait_for

  task automatic t_startup(input logic [7:0] level);
    int n;
    set_level = level;
    sd_pin = 1'h1;
    repeat (5) @(negedge sys_clk);
    check("sense_en", tsc_en, 1'h1);
    check("low_gate", lsg, 1'h0);
    wait_for(1, 8'h01, 40000, n);
    check("sample_time", n > POR + (level + 1) * SAMPLE_STEP_CYC - 12 &&
          n < POR + (level + 1) * SAMPLE_STEP_CYC + 12, 1'h1);
    check("set_code", set_code, level);
    check("trip_code", trip_code, level * 2);
    check("guard_en", guard_en, 1'h1);
    check("ramp_start", soft_ref, 6'h00);
    wait_for(2, 8'h3F, 2000, n);
    check("ramp_time", n >= 63 * SS - 2 && n <= 63 * SS + 2, 1'h1);
    $display("test startup done");
  endtask : t_startup

  task automatic t_narrow();
    int n;
    pwm_en = 1'h1;
    for (int w = 5; w >= 0; w -= 5)
    begin
      low_w = w;
      repeat (PER) @(negedge sys_clk);
      clear_max();
      repeat (4 * PER) @(negedge sys_clk);
      check("forced_width", low_max, MIN_LOW_CYC);
    end
    check("no_trip", hiccup, 1'h0);
    check("high_gate_on", hi_cnt > 0, 1'h1);
    short_on = 1'h1;
    wait_for(0, 8'h01, 3 * PER + 60, n);
    $display("test narrow done");
  endtask : t_narrow

  task automatic t_hiccup();
    int n;
    check("gates_off", {hsg, lsg}, 2'h0);
    low_w = 30;
    clear_max();
    wait_for(0, 8'h00, 3 * DUM, n);
    check("dummy_time", n >= 2 * DUM - 3 && n <= 2 * DUM + 3, 1'h1);
    check("dummy_gates", low_max, 0);
    wait_for(0, 8'h01, 4 * PER, n);
    check("blanking", low_run >= BLANK_CYC + 1 && low_run <= BLANK_CYC + 4, 1'h1);
    check("held_code", set_code, 7'h02);
    short_on = 1'h0;
    wait_for(0, 8'h00, 3 * DUM, n);
    check("retry_time", n >= 2 * DUM - 3 && n <= 2 * DUM + 3, 1'h1);
    wait_for(2, 8'h3F, 64 * SS + 10, n);
    check("recovered", hiccup, 1'h0);
    check("held_code2", set_code, 7'h02);
    $display("test hiccup done");
  endtask : t_hiccup

  task automatic t_shutdown();
    sd_pin = 1'h0;
    repeat (4) @(negedge sys_clk);
    check("sd_gates", {hsg, lsg}, 2'h0);
    check("sd_osc", osc_run, 1'h0);
    check("sd_amp", ea_en, 1'h0);
    t_startup(8'h03);
    check("overlap", overlap, 0);
    $display("test shutdown done");
  endtask : t_shutdown

  // main sequence
  initial
  begin
    repeat (6) @(negedge sys_clk);
    reset_n = 1'h1;
    @(negedge sys_clk);
    check("osc_idle", osc_run, 1'h0);
    t_startup(8'h02);
    t_narrow();
    t_hiccup();
    t_shutdown();
    results();
  end
endmodule : och_sequencer_tb
